// [logic/utx_pkg.sv]
// constants for the transmit endpoint control block
// assumes a 32-bit axi4-lite bus with word-aligned byte registers
package utx_pkg;
	// bus widths
	localparam int ADDR_W = 14;
	localparam int DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CSRL1 = 12'h112;
	localparam logic [11:0] IDX_CSRH1 = 12'h113;
	localparam logic [11:0] IDX_CSRH2 = 12'h123;
	localparam logic [11:0] IDX_CSRH3 = 12'h133;
	localparam logic [11:0] IDX_IRQ_STAT = 12'h140;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h141;
	// low control/status field positions
	localparam int BIT_PKT_RDY = 0;
	localparam int BIT_FIFO_NE = 1;
	localparam int BIT_UNDERRUN = 2;
	localparam int BIT_FLUSH = 3;
	localparam int BIT_SEND_STALL = 4;
	localparam int BIT_STALLED = 5;
	localparam int BIT_CLR_TOG = 6;
	// high control field positions
	localparam int BIT_TOGGLE = 0;
	localparam int BIT_HI_RSVD = 6;
	// interrupt status/mask layout
	localparam int IRQ_W = 3;
	localparam int IRQ_TX = 0;
	localparam int IRQ_STALL = 1;
	localparam int IRQ_UNDR = 2;
	// reset values
	localparam logic [7:0] CSRL_RST = 8'h00;
	localparam logic [7:0] CSRH_RST = 8'h00;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// number of high control registers
	localparam int NUM_HI = 3;
	// packet buffer depths
	localparam logic [1:0] DEPTH_SINGLE = 2'h1;
	localparam logic [1:0] DEPTH_DOUBLE = 2'h2;
	// bus responses
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// answer given to an in token
	typedef enum logic [1:0] {
		RESP_NONE,
		RESP_DATA,
		RESP_NAK,
		RESP_STALL
	} utx_resp_t;
endpackage

// [logic/utx_pkt_count.sv]
// packet occupancy counter of the transmit fifo
// assumes one-cycle strobes synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module utx_pkt_count (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic commit,
	input wire logic sent,
	input wire logic flushOne,
	input wire logic clearAll,
	input wire logic dblBuf,
	output logic [1:0] count,
	output logic full
);
	logic [1:0] count_q; // packets held
	logic [1:0] count_d; // next count
	logic [1:0] depth; // capacity in packets

	// capacity follows buffering mode
	assign depth = dblBuf ? utx_pkg::DEPTH_DOUBLE : utx_pkg::DEPTH_SINGLE;

	// add committed packet, drop sent or flushed one
	always_comb begin
		count_d = count_q;
		if (commit && count_d < depth) begin
			count_d = count_d + 2'h1;
		end
		if ((sent || flushOne) && count_d != 2'h0) begin
			count_d = count_d - 2'h1;
		end
		if (clearAll) begin // whole fifo emptied
			count_d = 2'h0;
		end
	end

	// occupancy register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			count_q <= 2'h0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
	assign full = (count_q >= depth);
endmodule
`default_nettype wire

// [logic/utx_irq_ctrl.sv]
// sticky interrupt status, mask and level interrupt line
// assumes event strobes and write strobes are one cycle wide
`timescale 1ns/1ns
`default_nettype none
module utx_irq_ctrl (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [2:0] events,
	input wire logic statWr,
	input wire logic maskWr,
	input wire logic [2:0] wrData,
	output logic [2:0] status,
	output logic [2:0] mask,
	output logic irq
);
	logic [2:0] stat_q; // sticky event bits
	logic [2:0] mask_q; // enables
	logic irq_q; // registered line

	// write one clears; a new event in the same cycle wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stat_q <= utx_pkg::IRQ_RST;
		end else begin
			stat_q <= (stat_q & ~(statWr ? wrData : 3'h0)) | events;
		end
	end

	// mask register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mask_q <= utx_pkg::IRQ_RST;
		end else if (maskWr) begin
			mask_q <= wrData;
		end
	end

	// level output, high while an enabled bit is set
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	assign status = stat_q;
	assign mask = mask_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

// [logic/utx_tx_ep_ctrl.sv]
// control and status logic of one device-mode transmit endpoint
// assumes an axi4-lite master on ref_clk and a usb link engine that
// gives one-cycle strobes synchronous to ref_clk
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Operation
// [R1] clear-toggle write clears the data toggle
// [R2] stall sent: flag, flush fifo, drop ready
// [R3] send-stall answers every in token with stall
// [R4] send-stall ignored in isochronous mode
// [R5] flush drops packet, resets pointer, raises interrupt
// [R6] flush with ready aborts packet being loaded
// [R7] software may flush twice when double buffered
// [R8] software flushes only while ready is set
// [R9] in token without ready sets underrun
// [R10] fifo-not-empty shows held packets
// [R11] software sets ready after loading whole packet
// [R12] packet sent clears ready, raises interrupt
// [R13] double buffer clears ready for next packet
// [R14] reserved bit reads zero
// [R15] low register resets to zero
// [R16] byte-wide high control register per endpoint
// [R17] writing zero clears status, hardware set wins
module utx_tx_ep_ctrl (
	input wire logic ref_clk,
	input wire logic sys_rst,
	// axi4-lite slave
	input wire logic [13:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [13:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link engine side
	input wire logic inTokenStb,
	input wire logic isoMode,
	input wire logic dblBufEn,
	input wire logic pktSentStb,
	input wire logic stallSentStb,
	input wire logic toggleFlipStb,
	output logic respData,
	output logic respNak,
	output logic respStall,
	output logic fifoPtrRst,
	output logic dataToggle,
	output logic fifoNotEmpty,
	output logic irq
);
	// ---- bus write channel state ----
	logic awHave_q; // address captured
	logic awHave_d;
	logic [13:0] awAddr_q; // captured address
	logic wHave_q; // data captured
	logic wHave_d;
	logic [31:0] wData_q; // captured data
	logic [3:0] wStrb_q; // captured strobes
	logic awReady_q;
	logic wReady_q;
	logic bValid_q;
	logic [1:0] bResp_q;
	logic wrEn; // write performed this cycle
	logic wrHit; // address decodes
	logic [7:0] wByte; // low byte of write data
	logic wLane0; // low byte lane enabled
	// ---- bus read channel state ----
	logic arReady_q;
	logic rValid_q;
	logic rValid_d;
	logic [31:0] rData_q;
	logic [1:0] rResp_q;
	logic [31:0] rdMux; // read data of addressed register
	logic rdHit; // read address decodes
	// ---- endpoint state ----
	logic pktRdy_q; // packet_ready
	logic pktRdy_d;
	logic sendStall_q; // send-stall control
	logic stalled_q; // stalled status
	logic underrun_q; // underrun_flag
	logic [7:0] hi_q [utx_pkg::NUM_HI]; // tx_endpoint_ctrl_high regs
	logic [7:0] csrl; // assembled low register
	// ---- decoded software actions ----
	logic wrLow; // write to low register
	logic wrStat; // write to interrupt status
	logic wrMask; // write to interrupt mask
	logic swSetRdy; // software raises packet_ready
	logic swFlush; // software flush
	logic swClrTog; // clear_toggle_cmd
	logic commit; // packet handed to fifo
	logic flushOne; // latest packet removed
	logic autoClr; // double-buffer hand-off
	// ---- link answers ----
	logic stallAns; // token gets stall
	logic [1:0] pktCount; // packets held
	logic fifoFull; // no room left
	utx_pkg::utx_resp_t resp; // answer to current token
	logic respData_q;
	logic respNak_q;
	logic respStall_q;
	logic ptrRst_q;
	logic fifo_not_empty_q;
	logic [2:0] irqEvents; // tx, stall, underrun events
	logic [2:0] irqStat; // sticky status
	logic [2:0] irqMask; // mask

	// ---------------- axi write path ----------------
	// a write happens once both halves are held and no response waits
	assign wrEn = awHave_q && wHave_q && !bValid_q;
	assign wByte = wData_q[7:0];
	assign wLane0 = wStrb_q[0];

	// address capture flag
	always_comb begin
		awHave_d = awHave_q;
		if (s_axi_awvalid && awReady_q) begin
			awHave_d = 1'b1;
		end else if (wrEn) begin
			awHave_d = 1'b0;
		end
	end

	// data capture flag
	always_comb begin
		wHave_d = wHave_q;
		if (s_axi_wvalid && wReady_q) begin
			wHave_d = 1'b1;
		end else if (wrEn) begin
			wHave_d = 1'b0;
		end
	end

	// write address and data holding registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awReady_q <= 1'b0;
			wReady_q <= 1'b0;
			awAddr_q <= 14'h0000;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
		end else begin
			awHave_q <= awHave_d;
			wHave_q <= wHave_d;
			awReady_q <= !awHave_d;
			wReady_q <= !wHave_d;
			if (s_axi_awvalid && awReady_q) begin
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wReady_q) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
		end
	end

	// write decode; registers sit at four times their index
	always_comb begin
		wrLow = 1'b0;
		wrStat = 1'b0;
		wrMask = 1'b0;
		wrHit = 1'b1;
		case (awAddr_q[13:2])
			utx_pkg::IDX_CSRL1: wrLow = wrEn && wLane0;
			utx_pkg::IDX_CSRH1: wrHit = 1'b1;
			utx_pkg::IDX_CSRH2: wrHit = 1'b1;
			utx_pkg::IDX_CSRH3: wrHit = 1'b1;
			utx_pkg::IDX_IRQ_STAT: wrStat = wrEn && wLane0;
			utx_pkg::IDX_IRQ_MASK: wrMask = wrEn && wLane0;
			default: wrHit = 1'b0;
		endcase
		if (awAddr_q[1:0] != 2'h0) begin // misaligned
			wrHit = 1'b0;
			wrLow = 1'b0;
			wrStat = 1'b0;
			wrMask = 1'b0;
		end
	end

	// write response, slverr on an unmapped address
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bValid_q <= 1'b0;
			bResp_q <= utx_pkg::AXI_OKAY;
		end else if (wrEn) begin
			bValid_q <= 1'b1;
			bResp_q <= wrHit ? utx_pkg::AXI_OKAY : utx_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			bValid_q <= 1'b0;
		end
	end

	// ---------------- software actions ----------------
	// flush together with ready aborts the loading packet
	assign swFlush = wrLow && wByte[utx_pkg::BIT_FLUSH];
	assign swSetRdy = wrLow && wByte[utx_pkg::BIT_PKT_RDY] && !pktRdy_q;
	assign commit = swSetRdy && !swFlush; // [R6]
	assign flushOne = swFlush && !swSetRdy; // [R5]
	assign swClrTog = wrLow && wByte[utx_pkg::BIT_CLR_TOG];
	// second buffer free: ready drops so the next packet can load
	assign autoClr = commit && dblBufEn && pktCount == 2'h0; // [R13]

	// occupancy of the transmit fifo
	utx_pkt_count u_count (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.commit(commit),
		.sent(pktSentStb),
		.flushOne(flushOne),
		.clearAll(stallSentStb), // [R2]
		.dblBuf(dblBufEn),
		.count(pktCount),
		.full(fifoFull)
	);

	// packet_ready: hardware clears take priority over the set
	always_comb begin
		pktRdy_d = pktRdy_q;
		if (commit && !fifoFull) begin
			pktRdy_d = 1'b1;
		end
		if (autoClr) begin
			pktRdy_d = 1'b0; // [R13]
		end
		if (pktSentStb) begin
			pktRdy_d = 1'b0; // [R12]
		end
		if (swFlush) begin
			pktRdy_d = 1'b0; // [R5]
		end
		if (stallSentStb) begin
			pktRdy_d = 1'b0; // [R2]
		end
	end

	// low register control bits; all clear at reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pktRdy_q <= utx_pkg::CSRL_RST[utx_pkg::BIT_PKT_RDY]; // [R15]
			sendStall_q <= utx_pkg::CSRL_RST[utx_pkg::BIT_SEND_STALL];
		end else begin
			pktRdy_q <= pktRdy_d;
			if (wrLow) begin // software holds stall until it clears it
				sendStall_q <= wByte[utx_pkg::BIT_SEND_STALL]; // [R3]
			end
		end
	end

	// stalled status: set on stall sent, software writes zero to clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stalled_q <= utx_pkg::CSRL_RST[utx_pkg::BIT_STALLED];
		end else if (stallSentStb) begin
			stalled_q <= 1'b1; // [R2] [R17]
		end else if (wrLow && !wByte[utx_pkg::BIT_STALLED]) begin
			stalled_q <= 1'b0; // [R17]
		end
	end

	// underrun status: in token while packet_ready is clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			underrun_q <= utx_pkg::CSRL_RST[utx_pkg::BIT_UNDERRUN];
		end else if (inTokenStb && !pktRdy_q) begin
			underrun_q <= 1'b1; // [R9] [R17]
		end else if (wrLow && !wByte[utx_pkg::BIT_UNDERRUN]) begin
			underrun_q <= 1'b0; // [R17]
		end
	end

	// high control registers; endpoint 1 bit 0 is the data toggle
	genvar gi;
	generate
		for (gi = 0; gi < utx_pkg::NUM_HI; gi++) begin : g_hi
			logic wrThis; // write to this high register
			logic [11:0] idx; // index of this register
			assign idx = (gi == 0) ? utx_pkg::IDX_CSRH1 :
				(gi == 1) ? utx_pkg::IDX_CSRH2 : utx_pkg::IDX_CSRH3;
			assign wrThis = wrEn && wLane0 && awAddr_q[1:0] == 2'h0 &&
				awAddr_q[13:2] == idx;
			// byte-wide store, reserved bit held at zero
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					hi_q[gi] <= utx_pkg::CSRH_RST; // [R16]
				end else begin
					if (wrThis) begin
						hi_q[gi] <= wByte & ~(8'h01 << utx_pkg::BIT_HI_RSVD);
					end
					if (gi == 0 && toggleFlipStb) begin // link flips toggle
						hi_q[gi][utx_pkg::BIT_TOGGLE] <=
							!hi_q[gi][utx_pkg::BIT_TOGGLE];
					end
					if (gi == 0 && swClrTog) begin
						hi_q[gi][utx_pkg::BIT_TOGGLE] <= 1'b0; // [R1]
					end
				end
			end
		end
	endgenerate

	// ---------------- link answers ----------------
	// stall only outside isochronous transfers
	assign stallAns = sendStall_q && !isoMode; // [R3] [R4]

	// choose the answer for a token
	always_comb begin
		resp = utx_pkg::RESP_NONE;
		if (inTokenStb) begin
			if (stallAns) begin
				resp = utx_pkg::RESP_STALL; // [R3]
			end else if (pktCount != 2'h0) begin
				resp = utx_pkg::RESP_DATA;
			end else begin
				resp = utx_pkg::RESP_NAK;
			end
		end
	end

	// registered answer strobes, pointer reset and fifo status
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			respData_q <= 1'b0;
			respNak_q <= 1'b0;
			respStall_q <= 1'b0;
			ptrRst_q <= 1'b0;
			fifo_not_empty_q <= 1'b0;
		end else begin
			respData_q <= resp == utx_pkg::RESP_DATA;
			respNak_q <= resp == utx_pkg::RESP_NAK;
			respStall_q <= resp == utx_pkg::RESP_STALL;
			ptrRst_q <= swFlush || stallSentStb; // [R5] [R6]
			fifo_not_empty_q <= pktCount != 2'h0; // [R10]
		end
	end

	// ---------------- interrupts ----------------
	assign irqEvents[utx_pkg::IRQ_TX] = pktSentStb || swFlush; // [R5] [R12]
	assign irqEvents[utx_pkg::IRQ_STALL] = stallSentStb;
	assign irqEvents[utx_pkg::IRQ_UNDR] = inTokenStb && !pktRdy_q;

	utx_irq_ctrl u_irq (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.events(irqEvents),
		.statWr(wrStat),
		.maskWr(wrMask),
		.wrData(wByte[2:0]),
		.status(irqStat),
		.mask(irqMask),
		.irq(irq)
	);

	// ---------------- axi read path ----------------
	// low register image; reserved, clear-toggle and flush read zero
	always_comb begin
		csrl = 8'h00; // [R14]
		csrl[utx_pkg::BIT_PKT_RDY] = pktRdy_q;
		csrl[utx_pkg::BIT_FIFO_NE] = fifo_not_empty_q; // [R10]
		csrl[utx_pkg::BIT_UNDERRUN] = underrun_q;
		csrl[utx_pkg::BIT_SEND_STALL] = sendStall_q;
		csrl[utx_pkg::BIT_STALLED] = stalled_q;
	end

	// read decode
	always_comb begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		case (s_axi_araddr[13:2])
			utx_pkg::IDX_CSRL1: rdMux[7:0] = csrl;
			utx_pkg::IDX_CSRH1: rdMux[7:0] = hi_q[0];
			utx_pkg::IDX_CSRH2: rdMux[7:0] = hi_q[1];
			utx_pkg::IDX_CSRH3: rdMux[7:0] = hi_q[2];
			utx_pkg::IDX_IRQ_STAT: rdMux[2:0] = irqStat;
			utx_pkg::IDX_IRQ_MASK: rdMux[2:0] = irqMask;
			default: rdHit = 1'b0;
		endcase
		if (s_axi_araddr[1:0] != 2'h0) begin
			rdHit = 1'b0;
			rdMux = 32'h00000000;
		end
	end

	// read valid next state
	always_comb begin
		rValid_d = rValid_q;
		if (s_axi_arvalid && arReady_q) begin
			rValid_d = 1'b1;
		end else if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
	end

	// read channel registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			arReady_q <= 1'b0;
			rValid_q <= 1'b0;
			rData_q <= 32'h00000000;
			rResp_q <= utx_pkg::AXI_OKAY;
		end else begin
			rValid_q <= rValid_d;
			arReady_q <= !rValid_d;
			if (s_axi_arvalid && arReady_q) begin
				rData_q <= rdMux;
				rResp_q <= rdHit ? utx_pkg::AXI_OKAY : utx_pkg::AXI_SLVERR;
			end
		end
	end

	// ---------------- outputs ----------------
	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign respData = respData_q;
	assign respNak = respNak_q;
	assign respStall = respStall_q;
	assign fifoPtrRst = ptrRst_q;
	assign dataToggle = hi_q[0][utx_pkg::BIT_TOGGLE];
	assign fifoNotEmpty = fifo_not_empty_q;
endmodule
`default_nettype wire

// [verification/utx_tx_ep_asserts.sv]
// port checker for the transmit endpoint control block
// assumes it is bound to utx_tx_ep_ctrl on its single clock
`timescale 1ns/1ns
`default_nettype none
module utx_tx_ep_asserts (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic inTokenStb,
	input wire logic isoMode,
	input wire logic stallSentStb,
	input wire logic toggleFlipStb,
	input wire logic respData,
	input wire logic respNak,
	input wire logic respStall,
	input wire logic fifoPtrRst,
	input wire logic dataToggle,
	input wire logic fifoNotEmpty,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// token answers: one per token, none otherwise, no stall in iso
	property p_one; inTokenStb |=> $onehot({respData, respNak, respStall}); endproperty
	a_one: assert property (p_one)
		else $error("token answer missing or doubled");
	property p_none; !inTokenStb |=> !(respData || respNak || respStall); endproperty
	a_none: assert property (p_none)
		else $error("answer without token");
	property p_iso; inTokenStb && isoMode |=> !respStall; endproperty
	a_iso: assert property (p_iso)
		else $error("stall answered in iso mode");
	// stall handshake empties the fifo
	property p_sptr; stallSentStb |=> fifoPtrRst; endproperty
	a_sptr: assert property (p_sptr)
		else $error("no pointer reset after stall");
	property p_sempty; stallSentStb |=> ##1 !fifoNotEmpty; endproperty
	a_sempty: assert property (p_sempty)
		else $error("fifo not empty after stall");
	// pointer reset only from stall or a completed write
	property p_pcause; fifoPtrRst |-> $past(stallSentStb) || $rose(s_axi_bvalid);
	endproperty
	a_pcause: assert property (p_pcause)
		else $error("pointer reset without cause");
	// toggle moves only by link flip or a register write
	property p_tcause; $changed(dataToggle) |-> $past(toggleFlipStb) ||
		$rose(s_axi_bvalid); endproperty
	a_tcause: assert property (p_tcause)
		else $error("toggle changed without cause");
	property p_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_byte: assert property (p_byte)
		else $error("upper read bytes not zero");
	property p_rst; disable iff (1'b0) sys_rst |=> !fifoNotEmpty && !dataToggle
		&& !irq && !fifoPtrRst; endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");
	c_stall: cover property (respStall);
	c_data: cover property (respData);
	c_flush: cover property (fifoPtrRst && !$past(stallSentStb));
endmodule
bind utx_tx_ep_ctrl utx_tx_ep_asserts u_chk (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
	.inTokenStb(inTokenStb), .isoMode(isoMode), .stallSentStb(stallSentStb),
	.toggleFlipStb(toggleFlipStb), .respData(respData), .respNak(respNak),
	.respStall(respStall), .fifoPtrRst(fifoPtrRst), .dataToggle(dataToggle),
	.fifoNotEmpty(fifoNotEmpty), .irq(irq));
`default_nettype wire

// [verification/utx_host_model.sv]
// host-side model: issues in tokens and reports the handshake
// assumes the endpoint answers a token on the cycle after it
`timescale 1ns/1ns
`default_nettype none
module utx_host_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic tokReq,
	input wire logic slow,
	input wire logic respData,
	input wire logic respNak,
	input wire logic respStall,
	output logic inTokenStb,
	output logic pktSentStb,
	output logic stallSentStb,
	output logic toggleFlipStb,
	output var utx_pkg::utx_resp_t seen,
	output logic done
);
	logic busy; // token outstanding
	logic [2:0] cnt; // delay before the handshake ends
	logic anyResp;
	assign anyResp = respData | respNak | respStall;
	// one token per request; data or stall ends after a short or long wait
	always_ff @(posedge ref_clk) begin
		inTokenStb <= 1'b0;
		pktSentStb <= 1'b0;
		stallSentStb <= 1'b0;
		toggleFlipStb <= 1'b0;
		if (sys_rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 3'h0;
			seen <= utx_pkg::RESP_NONE;
		end else if (!tokReq) begin
			done <= 1'b0;
		end else if (!busy && !done) begin
			inTokenStb <= 1'b1;
			busy <= 1'b1;
		end else if (busy && cnt == 3'h0 && anyResp) begin
			seen <= respStall ? utx_pkg::RESP_STALL
				: (respData ? utx_pkg::RESP_DATA : utx_pkg::RESP_NAK);
			cnt <= slow ? 3'h4 : 3'h1;
		end else if (busy && cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1) begin
				busy <= 1'b0;
				done <= 1'b1;
				pktSentStb <= (seen == utx_pkg::RESP_DATA);
				toggleFlipStb <= (seen == utx_pkg::RESP_DATA);
				stallSentStb <= (seen == utx_pkg::RESP_STALL);
			end
		end
	end
endmodule
`default_nettype wire

// [verification/usb_device_tx_endpoint_ctrl_tb_top.sv]
// self-checking bench for the transmit endpoint control block
// assumes the endpoint answers every token the host model issues
`timescale 1ns/1ns
`default_nettype none
module usb_device_tx_endpoint_ctrl_tb_top;
	localparam logic [1:0] OK = utx_pkg::AXI_OKAY;
	localparam logic [1:0] ER = utx_pkg::AXI_SLVERR;
	localparam logic [13:0] A_LO = {utx_pkg::IDX_CSRL1, 2'b00};
	localparam logic [13:0] A_H1 = {utx_pkg::IDX_CSRH1, 2'b00};
	localparam logic [13:0] A_H2 = {utx_pkg::IDX_CSRH2, 2'b00};
	localparam logic [13:0] A_IS = {utx_pkg::IDX_IRQ_STAT, 2'b00};
	localparam logic [13:0] A_IM = {utx_pkg::IDX_IRQ_MASK, 2'b00};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [13:0] awA = 14'h0000, arA = 14'h0000;
	logic [31:0] wD = 32'h00000000;
	logic [3:0] wS = 4'h0;
	logic awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
	logic isoMode = 1'b0, dblBufEn = 1'b0, tokReq = 1'b0, slow = 1'b0;
	logic awRdy, wRdy, bV, arRdy, rV, respData, respNak, respStall;
	logic inTokenStb, pktSentStb, stallSentStb, toggleFlipStb, done;
	logic fifoPtrRst, dataToggle, fifoNotEmpty, irq;
	logic [1:0] bRsp, rRsp;
	logic [31:0] rD;
	utx_pkg::utx_resp_t seen;
	int bad_count = 0, samples_checked = 0;
	int ptrCount = 0; // pointer reset pulses seen
	always #10 ref_clk = ~ref_clk;
	// count every one-cycle pointer reset pulse
	always @(posedge ref_clk) if (fifoPtrRst) ptrCount <= ptrCount + 1;
	utx_tx_ep_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
		.s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV),
		.s_axi_wready(wRdy), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
		.s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
		.s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rRsp),
		.s_axi_rvalid(rV), .s_axi_rready(rR), .inTokenStb(inTokenStb),
		.isoMode(isoMode), .dblBufEn(dblBufEn), .pktSentStb(pktSentStb),
		.stallSentStb(stallSentStb), .toggleFlipStb(toggleFlipStb),
		.respData(respData), .respNak(respNak), .respStall(respStall),
		.fifoPtrRst(fifoPtrRst), .dataToggle(dataToggle),
		.fifoNotEmpty(fifoNotEmpty), .irq(irq));
	utx_host_model host (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.tokReq(tokReq), .slow(slow), .respData(respData),
		.respNak(respNak), .respStall(respStall), .inTokenStb(inTokenStb),
		.pktSentStb(pktSentStb), .stallSentStb(stallSentStb),
		.toggleFlipStb(toggleFlipStb), .seen(seen), .done(done));
	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// a wait that used up its bound ends the run
	task automatic wdog(input int n);
		if (n >= 50) begin
			bad_count++;
			finish_test();
		end
	endtask
	// axi write: both halves offered together, each dropped when taken
	task automatic wr(input logic [13:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		awA <= a;
		wD <= {24'h000000, d};
		wS <= 4'hF;
		awV <= 1'b1;
		wV <= 1'b1;
		bR <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			if (awV && awRdy) awV <= 1'b0;
			if (wV && wRdy) wV <= 1'b0;
			n++;
		end while (!bV && n < 50);
		bR <= 1'b0;
		wdog(n);
		chk(32'(bRsp), 32'(er));
		@(posedge ref_clk);
	endtask
	// axi read with data and response compared
	task automatic rd(input logic [13:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		arA <= a;
		arV <= 1'b1;
		rR <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			if (arV && arRdy) arV <= 1'b0;
			n++;
		end while (!rV && n < 50);
		rR <= 1'b0;
		wdog(n);
		chk(rD, e);
		chk(32'(rRsp), 32'(er));
		@(posedge ref_clk);
	endtask
	// one in token through the host model, answer compared
	task automatic tok(input utx_pkg::utx_resp_t e);
		int n;
		tokReq <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!done && n < 50);
		wdog(n);
		chk(32'(seen), 32'(e));
		tokReq <= 1'b0;
		@(posedge ref_clk);
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd(A_LO, 32'h00000000, OK);
		rd(A_H1, 32'h00000000, OK);
		rd(14'h0000, 32'h00000000, ER);
		wr(14'h0000, 8'h01, ER);
		wr(A_IM, 8'h07, OK);
		tok(utx_pkg::RESP_NAK);
		rd(A_LO, 32'h00000004, OK);
		chk(32'(irq), 32'h00000001);
		wr(A_IM, 8'h00, OK);
		chk(32'(irq), 32'h00000000);
		wr(A_IM, 8'h07, OK);
		wr(A_IS, 8'h07, OK);
		chk(32'(irq), 32'h00000000);
		wr(A_LO, 8'h00, OK);
		rd(A_LO, 32'h00000000, OK);
		wr(A_LO, 8'h01, OK);
		rd(A_LO, 32'h00000003, OK);
		chk(32'(fifoNotEmpty), 32'h00000001);
		tok(utx_pkg::RESP_DATA);
		rd(A_LO, 32'h00000000, OK);
		rd(A_IS, 32'h00000001, OK);
		rd(A_H1, 32'h00000001, OK);
		wr(A_LO, 8'h40, OK);
		rd(A_H1, 32'h00000000, OK);
		chk(32'(dataToggle), 32'h00000000);
		wr(A_IS, 8'h07, OK);
		slow <= 1'b1;
		wr(A_LO, 8'h11, OK);
		tok(utx_pkg::RESP_STALL);
		rd(A_LO, 32'h00000030, OK);
		chk(32'(fifoNotEmpty), 32'h00000000);
		tok(utx_pkg::RESP_STALL);
		isoMode <= 1'b1;
		tok(utx_pkg::RESP_NAK);
		rd(A_LO, 32'h00000034, OK);
		isoMode <= 1'b0;
		slow <= 1'b0;
		wr(A_LO, 8'h00, OK);
		rd(A_LO, 32'h00000000, OK);
		wr(A_IS, 8'h07, OK);
		wr(A_LO, 8'h01, OK);
		wr(A_LO, 8'h09, OK);
		rd(A_LO, 32'h00000000, OK);
		rd(A_IS, 32'h00000001, OK);
		wr(A_LO, 8'h09, OK);
		rd(A_LO, 32'h00000000, OK);
		tok(utx_pkg::RESP_NAK);
		dblBufEn <= 1'b1;
		wr(A_LO, 8'h00, OK);
		wr(A_LO, 8'h01, OK);
		rd(A_LO, 32'h00000002, OK);
		wr(A_LO, 8'h01, OK);
		rd(A_LO, 32'h00000003, OK);
		wr(A_LO, 8'h08, OK);
		rd(A_LO, 32'h00000002, OK);
		wr(A_LO, 8'h08, OK);
		rd(A_LO, 32'h00000000, OK);
		tok(utx_pkg::RESP_NAK);
		wr(A_LO, 8'h80, OK);
		rd(A_LO, 32'h00000000, OK);
		wr(A_H2, 8'hFF, OK);
		rd(A_H2, 32'h000000BF, OK);
		// two stalls sent and four flush writes each reset the pointer
		chk(32'(ptrCount), 32'h00000006);
		finish_test();
	end
endmodule
`default_nettype wire
